// ### hw/alu_flags_map.svh
`ifndef ALU_FLAGS_MAP_SVH
`define ALU_FLAGS_MAP_SVH
`define FLAGS_ADDR        8'h00
`define FLAGS_RESET       8'h00
`define FLAGS_MASK        8'h1f
`define BIT_NEG           4
`define BIT_SWRAP         3
`define BIT_ZERO          2
`define BIT_HALF          1
`define BIT_WRAP          0
`define OP_ADD            4'h0
`define OP_SUB            4'h1
`define OP_AND            4'h2
`define OP_OR             4'h3
`define OP_XOR            4'h4
`define OP_CLEAR          4'h5
`define OP_PASS           4'h6
`define OP_SWAP           4'h7
`define OP_BCLR           4'h8
`define OP_BSET           4'h9
`define OP_COPY           4'ha
`endif

// ### hw/alu_flags_pkg.sv
package alu_flags_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] op_t;
endpackage

// ### hw/alu_core.sv
`timescale 1ns/1ps
`include "alu_flags_map.svh"
module alu_core
    import alu_flags_pkg::*;
(
    input  wire op_t   op,
    input  wire byte_t a,
    input  wire byte_t b,
    input  wire [2:0]  bit_sel,
    output byte_t      result,
    output logic [4:0] flags,
    output logic       flag_update
);
    logic [8:0] sum;
    logic [4:0] low;
    logic       ovf;
    always_comb begin
        sum         = 9'h0_00;
        low         = 5'h0_0;
        ovf         = 1'b0;
        result      = a;
        flag_update = 1'b1;
        case (op)
            `OP_ADD: begin
                sum    = {1'b0, a} + {1'b0, b};
                low    = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                result = sum[7:0];
                ovf    = (a[7] == b[7]) && (result[7] != a[7]);
            end
            `OP_SUB: begin
                sum    = {1'b0, a} + {1'b0, ~b} + 9'h0_01;
                low    = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h0_1;
                result = sum[7:0];
                ovf    = (a[7] != b[7]) && (result[7] != a[7]);
            end
            `OP_AND:   result = a & b;
            `OP_OR:    result = a | b;
            `OP_XOR:   result = a ^ b;
            `OP_CLEAR: result = 8'h0_0;
            `OP_PASS:  result = a;
            `OP_SWAP: begin
                result      = {a[3:0], a[7:4]};
                flag_update = 1'b0;
            end
            `OP_BCLR: begin
                result          = a;
                result[bit_sel] = 1'b0;
                flag_update     = 1'b0;
            end
            `OP_BSET: begin
                result          = a;
                result[bit_sel] = 1'b1;
                flag_update     = 1'b0;
            end
            default: begin
                result      = b;
                flag_update = 1'b0;
            end
        endcase
        flags = {result[7], ovf, (result == 8'h0_0), low[4], sum[8]};
    end
endmodule

// ### hw/alu_status_flags.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "alu_flags_map.svh"
// Operation
// - flag-updating op writing flag register keeps logic-made five flags
// - clear aimed at flag register sets zero flag, others unchanged
// - subtract: wrap and half carry are inverted borrows
// - flag register usable as source or destination like any register
module alu_status_flags
    import alu_flags_pkg::*;
(
    input  wire logic  CORE_CLK,
    input  wire logic  RESET,
    input  wire logic  EXEC,
    input  wire op_t   OP,
    input  wire byte_t SRC_ADDR,
    input  wire byte_t DST_ADDR,
    input  wire byte_t SRC_DATA,
    input  wire byte_t OPERAND_B,
    input  wire [2:0]  BIT_SEL,
    input  wire byte_t ADDR,
    input  wire byte_t WDATA,
    input  wire logic  WR,
    input  wire logic  RD,
    output byte_t      RDATA,
    output byte_t      RESULT,
    output logic       RESULT_VALID,
    output byte_t      FLAGS
);
    ////////////////////////////////////////////////////////////////
    byte_t      flag_reg;
    byte_t      operand_a;
    byte_t      alu_result;
    logic [4:0] alu_flags;
    logic       upd;
    byte_t      next_flags;
    logic       dst_flags;

    assign operand_a = (SRC_ADDR == `FLAGS_ADDR) ? flag_reg : SRC_DATA;
    assign dst_flags = (DST_ADDR == `FLAGS_ADDR);

    alu_core u_core (
        .op          (OP),
        .a           (operand_a),
        .b           (OPERAND_B),
        .bit_sel     (BIT_SEL),
        .result      (alu_result),
        .flags       (alu_flags),
        .flag_update (upd)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_flags = flag_reg;
        if (EXEC) begin
            if (OP == `OP_CLEAR && dst_flags) begin
                next_flags            = flag_reg;
                next_flags[`BIT_ZERO] = 1'b1;
            end else if (upd) begin
                next_flags = {3'b000, alu_flags};
            end else if (dst_flags) begin
                next_flags = alu_result & `FLAGS_MASK;
            end
        end else if (WR && ADDR == `FLAGS_ADDR) begin
            next_flags = WDATA & `FLAGS_MASK;
        end
    end

    // reset loads FLAGS_RESET; all flags are clear after reset
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            flag_reg <= `FLAGS_RESET;
        end else begin
            flag_reg <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            RESULT       <= 8'h0_0;
            RESULT_VALID <= 1'b0;
        end else begin
            RESULT       <= alu_result;
            RESULT_VALID <= EXEC && !dst_flags;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 8'h0_0;
        end else if (RD && ADDR == `FLAGS_ADDR) begin
            RDATA <= flag_reg;
        end else begin
            RDATA <= 8'h0_0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            FLAGS <= `FLAGS_RESET;
        end else begin
            FLAGS <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_clear_sets_zero;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_CLEAR && dst_flags) |=> (flag_reg == ($past(flag_reg) | (8'h0_1 << `BIT_ZERO)));
    endproperty
    a_clear_sets_zero: assert property (p_clear_sets_zero) else $error("clear of flags wrong");

    property p_suppress;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && upd && !(OP == `OP_CLEAR && dst_flags)) |=> (flag_reg[4:0] == $past(alu_flags));
    endproperty
    a_suppress: assert property (p_suppress) else $error("flag write not suppressed");

    property p_top_zero;
        @(posedge CORE_CLK) disable iff (RESET)
        flag_reg[7:5] == 3'b000;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("upper flag bits set");

    property p_sub_borrow;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_SUB && !dst_flags) |=> (flag_reg[`BIT_WRAP] == ($past(operand_a) >= $past(OPERAND_B)));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

    property p_copy_dst;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_COPY && dst_flags) |=> (flag_reg == ($past(OPERAND_B) & `FLAGS_MASK));
    endproperty
    a_copy_dst: assert property (p_copy_dst) else $error("copy to flags wrong");

    property p_read;
        @(posedge CORE_CLK) disable iff (RESET)
        (RD && ADDR == `FLAGS_ADDR) |=> (RDATA == $past(flag_reg));
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");

    property p_read_idle;
        @(posedge CORE_CLK) disable iff (RESET)
        !(RD && ADDR == `FLAGS_ADDR) |=> (RDATA == 8'h0_0);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not cleared");

    property p_valid_set;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && !dst_flags) |=> RESULT_VALID;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("result valid missing");

    property p_valid_clr;
        @(posedge CORE_CLK) disable iff (RESET)
        !(EXEC && !dst_flags) |=> !RESULT_VALID;
    endproperty
    a_valid_clr: assert property (p_valid_clr) else $error("result valid spurious");

    property p_src_flags;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_PASS && SRC_ADDR == `FLAGS_ADDR) |=> (RESULT == $past(flag_reg));
    endproperty
    a_src_flags: assert property (p_src_flags) else $error("flag register not read as source");

    property p_hold_other;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && !upd && !dst_flags) |=> (flag_reg == $past(flag_reg));
    endproperty
    a_hold_other: assert property (p_hold_other) else $error("flags changed by other op");

    property p_wr_flags;
        @(posedge CORE_CLK) disable iff (RESET)
        (!EXEC && WR && ADDR == `FLAGS_ADDR) |=> (flag_reg == ($past(WDATA) & `FLAGS_MASK));
    endproperty
    a_wr_flags: assert property (p_wr_flags) else $error("port write to flags wrong");

    property p_idle_hold;
        @(posedge CORE_CLK) disable iff (RESET)
        (!EXEC && !(WR && ADDR == `FLAGS_ADDR)) |=> (flag_reg == $past(flag_reg));
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("flags changed while idle");

    property p_bit_set;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_BSET && dst_flags && SRC_ADDR == `FLAGS_ADDR)
            |=> (flag_reg == (($past(flag_reg) | (8'h0_1 << $past(BIT_SEL))) & `FLAGS_MASK));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set on flags wrong");

    property p_bit_clr;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_BCLR && dst_flags && SRC_ADDR == `FLAGS_ADDR)
            |=> (flag_reg == ($past(flag_reg) & ~(8'h0_1 << $past(BIT_SEL)) & `FLAGS_MASK));
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear on flags wrong");

    property p_add_wrap;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_ADD)
            |=> (flag_reg[`BIT_WRAP] == (({1'b0, $past(operand_a)} + {1'b0, $past(OPERAND_B)}) > 9'h0_ff));
    endproperty
    a_add_wrap: assert property (p_add_wrap) else $error("add carry wrong");

    property p_add_half;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_ADD)
            |=> (flag_reg[`BIT_HALF] == (({1'b0, $past(operand_a[3:0])} + {1'b0, $past(OPERAND_B[3:0])}) > 5'h0_f));
    endproperty
    a_add_half: assert property (p_add_half) else $error("add half carry wrong");

    property p_sub_half;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && OP == `OP_SUB) |=> (flag_reg[`BIT_HALF] == ($past(operand_a[3:0]) >= $past(OPERAND_B[3:0])));
    endproperty
    a_sub_half: assert property (p_sub_half) else $error("digit borrow polarity wrong");

    property p_neg_copy;
        @(posedge CORE_CLK) disable iff (RESET)
        (EXEC && upd && !(OP == `OP_CLEAR && dst_flags)) |=> (flag_reg[`BIT_NEG] == RESULT[7]);
    endproperty
    a_neg_copy: assert property (p_neg_copy) else $error("negative flag wrong");

    property p_out_copy;
        @(posedge CORE_CLK) disable iff (RESET)
        FLAGS == flag_reg;
    endproperty
    a_out_copy: assert property (p_out_copy) else $error("flag output differs from register");
endmodule

// ### tb/tb_alu_status_flag_register.sv
`timescale 1ns/1ps
`include "alu_flags_map.svh"
module tb_alu_status_flag_register
    import alu_flags_pkg::*;
();
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        exec = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        result_valid;
    logic [2:0]  bit_sel = 3'h0;
    op_t         op = `OP_ADD;
    op_t         o;
    byte_t       src_addr = 8'h01, dst_addr = 8'h01, src_data = 8'h00, operand_b = 8'h00;
    byte_t       addr = 8'h00, wdata = 8'h00, rdata, result, flags, a, b, d, f, r, src;
    logic [15:0] corner [4] = '{16'h0000, 16'h8001, 16'h7f01, 16'h0001};
    int          bad_count = 0, cmp_count = 0, seed;

    always #2.5 core_clk = ~core_clk;

    alu_status_flags DUT (.CORE_CLK(core_clk), .RESET(reset), .EXEC(exec), .OP(op), .SRC_ADDR(src_addr),
        .DST_ADDR(dst_addr), .SRC_DATA(src_data), .OPERAND_B(operand_b), .BIT_SEL(bit_sel), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RESULT(result), .RESULT_VALID(result_valid),
        .FLAGS(flags));

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input byte_t got, input byte_t exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // subtract carries are inverted borrows
    function byte_t calc_flags(input op_t x_op, input byte_t x, input byte_t y, output byte_t res);
        logic [8:0] s;
        logic       c, dc, ov;
        c = 1'b0;
        dc = 1'b0;
        ov = 1'b0;
        if (x_op == `OP_SUB) begin
            s = {1'b0, x} - {1'b0, y};
            c = ~s[8];
            dc = x[3:0] >= y[3:0];
            ov = (x[7] != y[7]) && (s[7] != x[7]);
        end else if (x_op == `OP_ADD) begin
            s = {1'b0, x} + {1'b0, y};
            c = s[8];
            dc = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
            ov = (x[7] == y[7]) && (s[7] != x[7]);
        end else begin
            // logic ops and clear leave carries and overflow low
            case (x_op)
                `OP_AND: s = {1'b0, x & y};
                `OP_OR: s = {1'b0, x | y};
                `OP_XOR: s = {1'b0, x ^ y};
                `OP_CLEAR: s = 9'h000;
                default: s = {1'b0, x};
            endcase
        end
        res = s[7:0];
        return {3'b000, s[7], ov, s[7:0] == 8'h00, dc, c};
    endfunction

    task run(input op_t x_op, input byte_t sa, input byte_t da, input byte_t x, input byte_t y, input logic [2:0] k);
        @(posedge core_clk);
        exec <= 1'b1;
        op <= x_op;
        src_addr <= sa;
        dst_addr <= da;
        src_data <= x;
        operand_b <= y;
        bit_sel <= k;
        @(posedge core_clk);
        exec <= 1'b0;
        #1;
    endtask

    task wreg(input byte_t ad, input byte_t v);
        @(posedge core_clk);
        addr <= ad;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask

    task rreg(input byte_t ad, input byte_t exp);
        @(posedge core_clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge core_clk);
        #1;
        chk(rdata, 8'h00);
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, far above the real run length
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        print_verdict;
    end

    initial begin
        seed = $urandom(4647);
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk(flags, `FLAGS_RESET);
        wreg(`FLAGS_ADDR, 8'hff);
        rreg(`FLAGS_ADDR, 8'h1f);
        wreg(8'h5a, 8'h00);
        rreg(8'h5a, 8'h00);
        chk(flags, 8'h1f);
        for (int i = 0; i < 120; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            if (i < 4) {a, b} = corner[i];
            o = i[0] ? `OP_SUB : `OP_ADD;
            d = (i % 3 == 0) ? `FLAGS_ADDR : 8'h01;
            f = calc_flags(o, a, b, r);
            run(o, 8'h01, d, a, b, 3'h0);
            chk(flags, f);
            chk({7'h00, result_valid}, {7'h00, d != 8'h00});
            if (d != 8'h00) chk(result, r);
        end
        // logic ops, clear and pass, every other one reading the flag register
        for (int i = 0; i < 20; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            o = `OP_AND + 4'(i % 5);
            src = i[0] ? `FLAGS_ADDR : 8'h01;
            f = calc_flags(o, i[0] ? f : a, b, r);
            run(o, src, 8'h01, a, b, 3'h0);
            chk(flags, f);
            chk(result, r);
        end
        run(`OP_CLEAR, 8'h01, `FLAGS_ADDR, a, b, 3'h0);
        f = f | 8'h04;
        chk(flags, f);
        for (int k = 0; k < 8; k++) begin
            run(`OP_BSET, `FLAGS_ADDR, `FLAGS_ADDR, 8'h00, 8'h00, k[2:0]);
            f = (f | (8'h01 << k)) & `FLAGS_MASK;
            chk(flags, f);
            run(`OP_BCLR, `FLAGS_ADDR, `FLAGS_ADDR, 8'h00, 8'h00, k[2:0]);
            f = f & ~(8'h01 << k);
            chk(flags, f);
        end
        b = 8'($urandom);
        run(`OP_COPY, 8'h01, `FLAGS_ADDR, 8'h00, b, 3'h0);
        f = b & `FLAGS_MASK;
        chk(flags, f);
        run(`OP_SWAP, `FLAGS_ADDR, `FLAGS_ADDR, 8'h00, 8'h00, 3'h0);
        f = {f[3:0], f[7:4]} & `FLAGS_MASK;
        chk(flags, f);
        // write strobe beside an execute: the execute wins
        @(posedge core_clk);
        exec <= 1'b1;
        op <= `OP_COPY;
        src_addr <= 8'h01;
        dst_addr <= 8'h01;
        operand_b <= 8'($urandom);
        addr <= `FLAGS_ADDR;
        wdata <= ~f;
        wr <= 1'b1;
        @(posedge core_clk);
        exec <= 1'b0;
        wr <= 1'b0;
        #1;
        chk(flags, f);
        chk({7'h00, result_valid}, 8'h01);
        b = 8'($urandom);
        f = calc_flags(`OP_ADD, f, b, r);
        run(`OP_ADD, `FLAGS_ADDR, 8'h01, 8'h00, b, 3'h0);
        chk(result, r);
        chk(flags, f);
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk(flags, `FLAGS_RESET);
        print_verdict;
    end
endmodule
